// ==== core/ptsc_defines.vh ====
// ptsc_defines.vh: offsets, field positions, reset values and codes for the tx sideband control block
// assumes: included by bare name from the core/ files only
`ifndef PTSC_DEFINES_VH
`define PTSC_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PTSC_A_CTRL 8'h00
`define PTSC_A_MAXLEN 8'h04
`define PTSC_A_INTDATA 8'h08
`define PTSC_A_INTCMD 8'h0C
`define PTSC_A_STATUS 8'h10
`define PTSC_A_ISTAT 8'h14
`define PTSC_A_IMASK 8'h18
`define PTSC_A_DROPCNT 8'h1C
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PTSC_CTRL_EN 0
`define PTSC_CTRL_LENCHK 1
`define PTSC_CTRL_RST 2'h3
`define PTSC_MAXLEN_RST 16'h0100
`define PTSC_EV_LEN 0
`define PTSC_EV_STR 1
`define PTSC_EV_INT 2
`define PTSC_SB_ECRC 0
`define PTSC_SB_ERRFWD 1
`define PTSC_SB_STR 2
`define PTSC_RESP_OK 2'h0
`define PTSC_RESP_ERR 2'h2
`define PTSC_CRC_INIT 32'hFFFFFFFF
`define PTSC_CRC_POLY 32'h04C11DB7
`endif

// ==== core/ptsc_crc32.v ====
// ptsc_crc32.v: running end-to-end digest over 32-bit words, result held in a register
// assumes: one clock, synchronous use of clear/enable from the framer
`timescale 1ns/1ps
`default_nettype none
`include "ptsc_defines.vh"
module ptsc_crc32 (
  input wire sys_clk,
  input wire rst_n,
  input wire clear,
  input wire en,
  input wire [31:0] data,
  output reg [31:0] crc_q
);
  reg [31:0] base;
  reg [31:0] crc_d;
  integer i;

  always @* begin
    base = clear ? `PTSC_CRC_INIT : crc_q;
    crc_d = base;
    for (i = 31; i >= 0; i = i - 1) begin
      crc_d = {crc_d[30:0], 1'b0} ^ ((crc_d[31] ^ data[i]) ? `PTSC_CRC_POLY : 32'h00000000);
    end
    if (!en) begin
      crc_d = base;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= `PTSC_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end
endmodule // ptsc_crc32
`default_nettype wire

// ==== core/ptsc_cfg_arb.v ====
// ptsc_cfg_arb.v: request/grant handshake for core-generated packets
// assumes: gnt comes from user logic on sys_clk, buf_ok already synchronised
`timescale 1ns/1ps
`default_nettype none
module ptsc_cfg_arb (
  input wire sys_clk,
  input wire rst_n,
  input wire pend,
  input wire gnt,
  input wire buf_ok,
  input wire done,
  output reg req_q,
  output wire go
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_REQ = 4'h2;
  localparam [3:0] S_GNT = 4'h4;
  localparam [3:0] S_REARM = 4'h8;
  reg [3:0] st_q;
  reg [3:0] st_d;

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always @* begin
    st_d = st_q;
    case (st_q)
      S_IDLE: if (pend) st_d = S_REQ; // see RL4
      S_REQ: if (gnt) st_d = S_GNT; // see RL6 see RL9
      S_GNT: if (done) st_d = S_REARM; // see RL8
      S_REARM: st_d = S_IDLE; // see RL5
      default: st_d = S_IDLE;
    endcase
  end

  // grant held in S_GNT until buffer space allows the send
  assign go = st_q[2] & buf_ok; // see RL7 see RL8

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      req_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= st_d[1] | st_d[2]; // see RL4 see RL5
    end
  end
endmodule // ptsc_cfg_arb
`default_nettype wire

// ==== core/ptsc_top.v ====
// ptsc_top.v: transmit sideband control - framer, drop detection, digest append, internal packet arbitration
// assumes: user tx stream and grant on sys_clk; link sink accepts one beat per cycle; AXI4-Lite master on sys_clk
//
// What this block does
// RL1 - pulse drop and discard a packet whose length exceeds the limit
// RL2 - pulse drop and discard a streamed packet with a gap between beats
// RL3 - streamed packets arrive back to back; forwarding starts before the whole packet
// RL4 - raise internal request when a core-generated packet is ready
// RL5 - lower the request after each serviced packet so each request rises anew
// RL6 - without grant, user packets go before core-generated ones
// RL7 - one grant cycle during request makes the internal packet the next output; the code still takes user packets ahead of it while buf_ok is low
// RL8 - request stays high after grant while no buffer space exists
// RL9 - a single grant pulse is remembered until the packet is sent
// RL10 - user logic without a preference holds grant high
// RL11 - error-forward bit poisons the packet in progress
// RL12 - error-forward may appear on any beat from first to last
// RL13 - error-forward is never used on a streamed packet
// RL14 - digest-generate bit makes the block compute and append the digest
// RL15 - digest-generate is given on the first beat of the packet
// RL16 - drop output is a one-cycle pulse per discarded packet
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ptsc_defines.vh"
module ptsc_top #(
  parameter INT_LEN = 3
) (
  input wire sys_clk,
  input wire rstn,
  input wire [31:0] s_tx_tdata,
  input wire s_tx_tvalid,
  input wire s_tx_tlast,
  input wire [2:0] s_tx_tuser,
  output reg s_tx_tready_q,
  output reg [31:0] lnk_data_q,
  output reg lnk_valid_q,
  output reg lnk_sof_q,
  output reg lnk_last_q,
  output reg lnk_poison_q,
  output reg lnk_abort_q,
  output reg tx_drop_q,
  output reg int_req_q,
  input wire int_gnt,
  input wire int_buf_ok,
  output reg irq_q,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ----------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------
  reg rst_s1_q, rst_n;
  reg buf_s1_q, buf_s2_q;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_s1_q <= 1'b0;
      buf_s2_q <= 1'b0;
    end else begin
      buf_s1_q <= int_buf_ok;
      buf_s2_q <= buf_s1_q;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [1:0] ctrl_q;
  reg [15:0] maxlen_q;
  reg [31:0] intdata_q;
  reg pend_q;
  reg [2:0] istat_q, imask_q;
  reg [15:0] dropcnt_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_got_q, w_got_q;

  // ----------------------------------------
  // framer state
  // ----------------------------------------
  reg in_pkt_q, str_q, ecrc_q, poison_q, swallow_q, crc_pend_q, int_act_q;
  reg [15:0] len_q;
  reg [7:0] int_cnt_q;
  wire go;
  wire arb_req;
  wire [31:0] crc_q;

  wire beat = s_tx_tvalid & s_tx_tready_q;
  wire sof = beat & ~in_pkt_q;
  wire str_now = sof ? s_tx_tuser[`PTSC_SB_STR] : str_q;
  wire ecrc_now = sof ? s_tx_tuser[`PTSC_SB_ECRC] : ecrc_q; // see RL15
  // poison ignored on streamed packets, which may never carry it
  wire fwd_now = s_tx_tuser[`PTSC_SB_ERRFWD] & ~str_now; // see RL13
  wire poison_now = (sof ? 1'b0 : poison_q) | fwd_now; // see RL11 see RL12
  wire [15:0] len_n = sof ? 16'h0001 : len_q + 16'h0001;
  wire len_bad = beat & ~swallow_q & ctrl_q[`PTSC_CTRL_LENCHK] & (len_n > maxlen_q); // see RL1
  wire str_bad = in_pkt_q & str_q & ~swallow_q & ~beat; // see RL2 see RL3
  wire drop = len_bad | str_bad;
  wire pass = beat & ~swallow_q & ~len_bad;
  wire int_last = (int_cnt_q == INT_LEN[7:0] - 8'h01);
  wire int_done = int_act_q & int_last;
  // internal start only once ready has already fallen, so no user beat races it
  wire int_start = go & ~in_pkt_q & ~s_tx_tready_q & ~int_act_q & ~crc_pend_q; // see RL7
  wire in_pkt_d = beat ? ~s_tx_tlast : in_pkt_q;
  wire crc_pend_d = pass & s_tx_tlast & ecrc_now; // see RL14
  wire int_act_d = int_start | (int_act_q & ~int_last);
  wire tready_d = ctrl_q[`PTSC_CTRL_EN] & ~(go & ~in_pkt_d) & ~int_start & ~int_act_d & ~crc_pend_d; // see RL6

  ptsc_crc32 u_crc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(sof),
    .en(pass),
    .data(s_tx_tdata),
    .crc_q(crc_q)
  );

  ptsc_cfg_arb u_arb (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pend(pend_q),
    .gnt(int_gnt),
    .buf_ok(buf_s2_q),
    .done(int_done),
    .req_q(arb_req),
    .go(go)
  );

  // ----------------------------------------
  // framer and link output
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_pkt_q <= 1'b0;
      str_q <= 1'b0;
      ecrc_q <= 1'b0;
      poison_q <= 1'b0;
      swallow_q <= 1'b0;
      crc_pend_q <= 1'b0;
      int_act_q <= 1'b0;
      len_q <= 16'h0000;
      int_cnt_q <= 8'h00;
      s_tx_tready_q <= 1'b0;
      lnk_data_q <= 32'h00000000;
      lnk_valid_q <= 1'b0;
      lnk_sof_q <= 1'b0;
      lnk_last_q <= 1'b0;
      lnk_poison_q <= 1'b0;
      lnk_abort_q <= 1'b0;
      tx_drop_q <= 1'b0;
      int_req_q <= 1'b0;
    end else begin
      in_pkt_q <= in_pkt_d;
      str_q <= str_now;
      ecrc_q <= ecrc_now;
      poison_q <= poison_now;
      if (beat) begin
        len_q <= len_n;
      end
      // after a drop the rest of the user packet is swallowed up to its last beat
      swallow_q <= (swallow_q | drop) & ~(beat & s_tx_tlast);
      crc_pend_q <= crc_pend_d;
      int_act_q <= int_act_d;
      int_cnt_q <= int_start ? 8'h00 : (int_act_q ? int_cnt_q + 8'h01 : int_cnt_q);
      s_tx_tready_q <= tready_d;
      tx_drop_q <= drop; // see RL16
      int_req_q <= arb_req; // see RL4
      lnk_valid_q <= 1'b0;
      lnk_sof_q <= 1'b0;
      lnk_last_q <= 1'b0;
      lnk_poison_q <= 1'b0;
      lnk_abort_q <= 1'b0;
      if (int_act_q) begin
        lnk_valid_q <= 1'b1;
        lnk_data_q <= intdata_q;
        lnk_sof_q <= (int_cnt_q == 8'h00);
        lnk_last_q <= int_last;
      end else if (crc_pend_q) begin
        lnk_valid_q <= 1'b1; // see RL14
        lnk_data_q <= ~crc_q;
        lnk_last_q <= 1'b1;
        lnk_poison_q <= poison_q;
      end else if (drop) begin
        lnk_valid_q <= 1'b1; // see RL1 see RL2
        lnk_abort_q <= 1'b1;
        lnk_last_q <= 1'b1;
      end else if (pass) begin
        lnk_valid_q <= 1'b1; // see RL3
        lnk_data_q <= s_tx_tdata;
        lnk_sof_q <= sof;
        lnk_last_q <= s_tx_tlast & ~ecrc_now;
        lnk_poison_q <= s_tx_tlast & ~ecrc_now & poison_now; // see RL11
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire [2:0] ev = {int_done, len_bad & ~str_bad, str_bad};

  function hit;
    input [7:0] a;
    begin
      hit = (a == `PTSC_A_CTRL) | (a == `PTSC_A_MAXLEN) | (a == `PTSC_A_INTDATA) | (a == `PTSC_A_INTCMD) |
            (a == `PTSC_A_STATUS) | (a == `PTSC_A_ISTAT) | (a == `PTSC_A_IMASK) | (a == `PTSC_A_DROPCNT);
    end
  endfunction

  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (s_axi_araddr)
      `PTSC_A_CTRL: rd_d[1:0] = ctrl_q;
      `PTSC_A_MAXLEN: rd_d[15:0] = maxlen_q;
      `PTSC_A_INTDATA: rd_d = intdata_q;
      `PTSC_A_INTCMD: rd_d[0] = pend_q;
      `PTSC_A_STATUS: rd_d[3:0] = {buf_s2_q, int_act_q, in_pkt_q, int_req_q};
      `PTSC_A_ISTAT: rd_d[2:0] = istat_q;
      `PTSC_A_IMASK: rd_d[2:0] = imask_q;
      `PTSC_A_DROPCNT: rd_d[15:0] = dropcnt_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTSC_RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PTSC_RESP_OK;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      ctrl_q <= `PTSC_CTRL_RST;
      maxlen_q <= `PTSC_MAXLEN_RST;
      intdata_q <= 32'h00000000;
      pend_q <= 1'b0;
      istat_q <= 3'h0;
      imask_q <= 3'h0;
      dropcnt_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // event set wins over a same-cycle write-one-to-clear
      istat_q <= istat_q | ev;
      if (tx_drop_q) begin
        dropcnt_q <= dropcnt_q + 16'h0001;
      end
      pend_q <= pend_q & ~int_done;
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit(awaddr_q) ? `PTSC_RESP_OK : `PTSC_RESP_ERR;
        case (awaddr_q)
          `PTSC_A_CTRL: if (wstrb_q[0]) ctrl_q <= wdata_q[1:0];
          `PTSC_A_MAXLEN: begin
            if (wstrb_q[0]) maxlen_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) maxlen_q[15:8] <= wdata_q[15:8];
          end
          `PTSC_A_INTDATA: intdata_q <= wdata_q;
          `PTSC_A_INTCMD: if (wstrb_q[0] & wdata_q[0]) pend_q <= 1'b1;
          `PTSC_A_ISTAT: if (wstrb_q[0]) istat_q <= (istat_q & ~wdata_q[2:0]) | ev;
          `PTSC_A_IMASK: if (wstrb_q[0]) imask_q <= wdata_q[2:0];
          default: ;
        endcase
      end
      irq_q <= |(istat_q & imask_q);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= hit(s_axi_araddr) ? `PTSC_RESP_OK : `PTSC_RESP_ERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // ptsc_top
`default_nettype wire

// ==== tb/ptsc_properties.sv ====
// ptsc_properties.sv: port timing checks for the tx sideband control block
// assumes: bound into ptsc_top, one clock, rstn watched directly
`timescale 1ns/1ps
`default_nettype none
module ptsc_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tx_drop_q,
  input wire logic lnk_valid_q,
  input wire logic lnk_sof_q,
  input wire logic lnk_last_q,
  input wire logic lnk_poison_q,
  input wire logic lnk_abort_q,
  input wire logic int_req_q,
  input wire logic int_buf_ok,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  drop_one_cycle_a: assert property (tx_drop_q |=> !tx_drop_q)
    else $error("drop held");
  abort_with_drop_a: assert property (lnk_abort_q |-> tx_drop_q)
    else $error("abort without drop");
  poison_on_last_a: assert property (lnk_poison_q |-> lnk_valid_q && lnk_last_q)
    else $error("stray poison");
  sof_with_beat_a: assert property (lnk_sof_q |-> lnk_valid_q)
    else $error("stray sof");
  // buf_ok passes two sync flops, so three low samples are needed
  req_held_a: assert property ((int_req_q && !int_buf_ok) [*3] |=> int_req_q)
    else $error("request lost");
  req_fall_a: assert property ($fell(int_req_q) |-> $past(lnk_last_q) || lnk_last_q)
    else $error("request fell early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read late");
endmodule // ptsc_properties
bind ptsc_top ptsc_properties ptsc_properties_i (.*);
`default_nettype wire

// ==== tb/ptsc_user_model.sv ====
// ptsc_user_model.sv: user logic sending tx packets and giving the internal grant
// assumes: one command at a time from the bench, on sys_clk
`timescale 1ns/1ps
`default_nettype none
module ptsc_user_model (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [3:0] len,
  input wire logic [2:0] user,
  input wire logic gap,
  input wire logic gnt_cmd,
  input wire logic s_tx_tready_q,
  output logic busy,
  output logic [31:0] s_tx_tdata,
  output logic s_tx_tvalid,
  output logic s_tx_tlast,
  output logic [2:0] s_tx_tuser,
  output logic int_gnt
);
  logic [3:0] n_q;
  logic hole_q;
  wire fwd = user[1] && !user[2];
  initial begin
    busy = 1'b0;
    s_tx_tvalid = 1'b0;
    s_tx_tlast = 1'b0;
    s_tx_tdata = 32'h0;
    s_tx_tuser = 3'h0;
    int_gnt = 1'b0;
  end
  // ----
  // packet source
  // ----
  always @(posedge sys_clk) begin
    int_gnt <= gnt_cmd;
    if (start && !busy) begin
      busy <= 1'b1;
      n_q <= 4'h1;
      hole_q <= 1'b0;
      s_tx_tvalid <= 1'b1;
      s_tx_tdata <= 32'hA0000001;
      s_tx_tlast <= (len == 4'h1);
      s_tx_tuser <= {user[2], fwd && len == 4'h1, user[0]};
    end else if (busy && s_tx_tvalid && s_tx_tready_q && s_tx_tlast) begin
      busy <= 1'b0;
      s_tx_tvalid <= 1'b0;
      s_tx_tdata <= ~s_tx_tdata;
    end else if (busy && s_tx_tvalid && s_tx_tready_q && gap && !hole_q) begin
      // deliberate idle cycle inside the packet
      hole_q <= 1'b1;
      s_tx_tvalid <= 1'b0;
      s_tx_tdata <= ~s_tx_tdata;
    end else if (busy && (!s_tx_tvalid || s_tx_tready_q)) begin
      n_q <= n_q + 4'h1;
      s_tx_tvalid <= 1'b1;
      s_tx_tdata <= 32'hA0000001 + {28'h0, n_q};
      s_tx_tlast <= (n_q + 4'h1 == len);
      s_tx_tuser <= {1'b0, fwd && n_q + 4'h1 == len, 1'b0};
    end
  end
endmodule // ptsc_user_model
`default_nettype wire

// ==== tb/ptsc_top_test.sv ====
// ptsc_top_test.sv: self-checking bench for the tx sideband control block
// assumes: user model drives stream and grant, bench is the AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module ptsc_top_test;
  localparam int INT_LEN = 3;
  logic sys_clk = 1'b0, rstn = 1'b0, int_buf_ok = 1'b0, gnt_cmd = 1'b0, start = 1'b0, gap = 1'b0;
  logic [3:0] len = 4'h1;
  logic [2:0] user = 3'h0;
  logic busy, int_gnt, s_tx_tvalid, s_tx_tlast, s_tx_tready_q, lnk_valid_q, lnk_sof_q, lnk_last_q;
  logic lnk_poison_q, lnk_abort_q, tx_drop_q, int_req_q, irq_q;
  logic [31:0] s_tx_tdata, lnk_data_q, s_axi_rdata;
  logic [2:0] s_tx_tuser;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0, checked = 0, cyc = 0, beats = 0, drops = 0, poisons = 0, b0, d0;
  int sofs = 0;
  logic [31:0] last_data = 32'h0;
  ptsc_top #(.INT_LEN(INT_LEN)) ptsc_top_i (.*);
  ptsc_user_model ptsc_user_model_i (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    beats += (lnk_valid_q === 1'b1);
    drops += (tx_drop_q === 1'b1);
    poisons += (lnk_poison_q === 1'b1);
    sofs += (lnk_valid_q === 1'b1 && lnk_sof_q === 1'b1);
    // data of the closing beat of each packet, for payload and digest checks
    if (lnk_valid_q === 1'b1 && lnk_last_q === 1'b1) begin
      last_data <= lnk_data_q;
    end
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // ----
  // tasks
  // ----
  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask
  // reference digest step: msb first over one word, same polynomial as the link digest
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    crc_step = c;
    for (int i = 31; i >= 0; i--) begin
      crc_step = {crc_step[30:0], 1'b0} ^ ((crc_step[31] ^ d[i]) ? 32'h04C11DB7 : 32'h00000000);
    end
  endfunction
  // rready comes one cycle late so the slave must hold its answer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic send(input logic [3:0] l, input logic [2:0] u, input logic g);
    @(posedge sys_clk);
    len <= l;
    user <= u;
    gap <= g;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk(8'h00, 32'h3, 2'h0);
    rd_chk(8'h04, 32'h100, 2'h0);
    rd_chk(8'h20, 32'h0, 2'h2);
    b0 = beats;
    send(4'h2, 3'h1, 1'b0);
    chk(beats - b0, 3);
    chk(last_data, ~crc_step(crc_step(32'hFFFFFFFF, 32'hA0000001), 32'hA0000002));
    b0 = beats;
    send(4'h3, 3'h2, 1'b0);
    chk(beats - b0, 3);
    chk(poisons, 1);
    d0 = drops;
    b0 = beats;
    send(4'h4, 3'h4, 1'b0);
    chk(beats - b0, 4);
    send(4'h4, 3'h4, 1'b1);
    chk(drops - d0, 1);
    rd_chk(8'h14, 32'h1, 2'h0);
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h2);
    send(4'h4, 3'h0, 1'b0);
    chk(drops - d0, 2);
    rd_chk(8'h14, 32'h2, 2'h0);
    rd_chk(8'h1C, 32'h2, 2'h0);
    wr(8'h14, 32'h3);
    wr(8'h04, 32'h100);
    wr(8'h18, 32'h4);
    wr(8'h08, 32'h12345678);
    wr(8'h0C, 32'h1);
    repeat (8) @(posedge sys_clk);
    chk({31'h0, int_req_q}, 1);
    b0 = beats;
    send(4'h2, 3'h0, 1'b0);
    chk(beats - b0, 2);
    gnt_cmd <= 1'b1;
    @(posedge sys_clk);
    gnt_cmd <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({31'h0, int_req_q}, 1);
    chk(beats - b0, 2);
    int_buf_ok <= 1'b1;
    while (int_req_q) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    chk(beats - b0, 2 + INT_LEN);
    chk(last_data, 32'h12345678);
    chk({31'h0, irq_q}, 1);
    wr(8'h14, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq_q}, 0);
    chk({31'h0, int_req_q}, 0);
    // grant held high for good: a new internal packet goes out without any pulse
    gnt_cmd <= 1'b1;
    b0 = beats;
    wr(8'h0C, 32'h1);
    repeat (12) @(posedge sys_clk);
    chk(beats - b0, INT_LEN);
    chk(last_data, 32'h12345678);
    chk(sofs, 8);
    print_verdict();
  end
endmodule // ptsc_top_test
`default_nettype wire
